// File: core/metering_cfg_pkg.sv
package metering_cfg_pkg;

    // Register offsets
    localparam logic [15:0] PHASE_SIGN_STATUS_ADDR = 16'he617;
    localparam logic [15:0] DATAPATH_CONFIG_ADDR   = 16'he618;
    localparam logic [15:0] MEASUREMENT_MODE_ADDR  = 16'he700;
    localparam logic [15:0] ACCUMULATION_MODE_ADDR = 16'he701;

    // Reset values
    localparam logic [15:0] DATAPATH_CONFIG_RST   = 16'h0000;
    localparam logic [7:0]  MEASUREMENT_MODE_RST  = 8'h1c;
    localparam logic [7:0]  ACCUMULATION_MODE_RST = 8'h00;

    // Implemented bit masks (writable, or readable for PHASE_SIGN_MASK); everything else except soft reset bit 7 is reserved
    localparam logic [15:0] DATAPATH_CONFIG_MASK   = 16'h3f79;
    localparam logic [7:0]  MEASUREMENT_MODE_MASK  = 8'h1f;
    localparam logic [7:0]  ACCUMULATION_MODE_MASK = 8'h3f;
    localparam logic [15:0] PHASE_SIGN_MASK        = 16'h01ff;

    // Datapath configuration fields
    localparam int INTEGRATOR_ON_BIT      = 0;
    localparam int CHANNEL_SWAP_BIT       = 3;
    localparam int VOLTAGE_ADC_GROUND_BIT = 4;
    localparam int CURRENT_ADC_GROUND_BIT = 5;
    localparam int CAPTURE_PORT_ON_BIT    = 6;
    localparam int SOFT_RESET_BIT         = 7;
    localparam int PHASE_A_PICK_LSB       = 8;
    localparam int PHASE_B_PICK_LSB       = 10;
    localparam int PHASE_C_PICK_LSB       = 12;

    // Measurement mode fields
    localparam int PERIOD_SOURCE_LSB = 0;
    localparam int PEAK_PICK_LSB     = 2;

    // Accumulation mode fields
    localparam int ACTIVE_ACCUM_LSB   = 0;
    localparam int REACTIVE_ACCUM_LSB = 2;
    localparam int CONNECTION_LSB     = 4;

    // Mode codes
    localparam logic [1:0] ACTIVE_ABSOLUTE    = 2'h3;
    localparam logic [1:0] REACTIVE_BY_ACTIVE = 2'h2;
    localparam logic [1:0] CONN_THREE_WIRE    = 2'h1;
    localparam logic [1:0] CODE_RESERVED      = 2'h3;

endpackage

// File: core/metering_datapath_config.sv
// Operation
// [RULE1] Bit 0 enables integrator on all phase and neutral currents.
// [RULE2] Swap bit 3 exchanges voltage and current channel outputs.
// [RULE3] Bit 4 forces voltage converter outputs to ground level.
// [RULE4] Bit 5 forces current converter outputs to ground level.
// [RULE5] Bit 6 routes capture clock to shared pin; clear routes third pulse.
// [RULE6] Writing 1 to bit 7 starts a software reset.
// [RULE7] Bits 9:8 pick voltage for phase A current; 11 acts as 00.
// [RULE8] Bits 11:10 pick voltage for phase B current; 11 acts as 00.
// [RULE9] Bits 13:12 pick voltage for phase C current; 11 acts as 00.
// [RULE10] Period source bits 1:0 pick period phase; 11 acts as 00.
// [RULE11] Peak pick bits 2..4 include phases A..C; all default set.
// [RULE12] Several picked phases shorten the peak window.
// [RULE13] Active mode 00 signed, 11 absolute; 01 and 10 act as 00.
// [RULE14] Reactive mode 00 signed; 01 and 11 act as 00.
// [RULE15] Reactive mode 10 flips reactive sign on negative active power.
// [RULE16] Connection bits 5:4 steer accumulator inputs; 00 is four-wire.
// [RULE17] Connection code 01 zeroes all phase B energy products.
// [RULE18] Reserved bits ignore writes, read zero, change nothing.
`timescale 1ns/1ps
module metering_datapath_config #(
    parameter int SW = 24,
    parameter int PW = 32
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [15:0]          regAddr,
    input  wire logic                 regWrite,
    input  wire logic [15:0]          regWrData,
    output logic      [15:0]          regRdData,
    input  wire logic [8:0]           signFlags,
    output logic                      integratorOn,
    output logic                      softResetPulse,
    input  wire logic [2:0][SW-1:0]   voltAdc,
    input  wire logic [2:0][SW-1:0]   currAdc,
    output logic      [2:0][SW-1:0]   voltChan,
    output logic      [2:0][SW-1:0]   currChan,
    output logic      [2:0][SW-1:0]   pairedVolt,
    input  wire logic                 captureClock,
    input  wire logic                 thirdPulse,
    output logic                      sharedPin,
    output logic                      capturePortOn,
    input  wire logic [2:0]           zeroCross,
    output logic      [1:0]           periodPhase,
    output logic                      periodCross,
    output logic      [2:0]           peakPhases,
    input  wire logic [7:0]           peakCycles,
    output logic                      peakWindowEnd,
    input  wire logic [2:0][PW-1:0]   activePower,
    input  wire logic [2:0][PW-1:0]   reactivePower,
    input  wire logic [2:0][PW-1:0]   apparentPower,
    output logic      [2:0][PW-1:0]   activeTerm,
    output logic      [2:0][PW-1:0]   reactiveTerm,
    output logic      [2:0][PW-1:0]   apparentTerm,
    output logic      [1:0]           connectionSelect
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [15:0] config_q;
    logic [7:0]  measMode_q;
    logic [7:0]  accumulation_mode_q;
    logic        softReset_q;
    logic [15:0] rdData_q;

    wire hitConfig = regAddr == metering_cfg_pkg::DATAPATH_CONFIG_ADDR;
    wire hitMeas   = regAddr == metering_cfg_pkg::MEASUREMENT_MODE_ADDR;
    wire hitAcc    = regAddr == metering_cfg_pkg::ACCUMULATION_MODE_ADDR;
    wire hitSign   = regAddr == metering_cfg_pkg::PHASE_SIGN_STATUS_ADDR;
    wire wrConfig  = regWrite && hitConfig;
    wire wrMeas    = regWrite && hitMeas;
    wire wrAcc     = regWrite && hitAcc;
    wire resetReq  = wrConfig && regWrData[metering_cfg_pkg::SOFT_RESET_BIT];

    // Soft reset bit self-clears and never reads back set
    wire [15:0] configWr =
        regWrData & metering_cfg_pkg::DATAPATH_CONFIG_MASK; // RULE18

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            softReset_q <= 1'b0;
        end else begin
            softReset_q <= resetReq; // RULE6
        end
    end

    // Software reset returns the bank to defaults one cycle after the registered pulse, two cycles after request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            config_q   <= metering_cfg_pkg::DATAPATH_CONFIG_RST;
            measMode_q <= metering_cfg_pkg::MEASUREMENT_MODE_RST;
            accumulation_mode_q  <= metering_cfg_pkg::ACCUMULATION_MODE_RST;
        end else if (softReset_q) begin
            config_q   <= metering_cfg_pkg::DATAPATH_CONFIG_RST; // RULE6
            measMode_q <= metering_cfg_pkg::MEASUREMENT_MODE_RST;
            accumulation_mode_q  <= metering_cfg_pkg::ACCUMULATION_MODE_RST;
        end else begin
            if (wrConfig && !resetReq) begin
                config_q <= configWr;
            end
            if (wrMeas) begin
                measMode_q <= regWrData[7:0]
                    & metering_cfg_pkg::MEASUREMENT_MODE_MASK; // RULE18
            end
            if (wrAcc) begin
                accumulation_mode_q <= regWrData[7:0]
                    & metering_cfg_pkg::ACCUMULATION_MODE_MASK; // RULE18
            end
        end
    end

    // Read data registered; unmapped addresses answer zero
    wire [15:0] rdMux =
        hitConfig ? config_q :
        hitMeas   ? {8'h00, measMode_q} :
        hitAcc    ? {8'h00, accumulation_mode_q} :
        hitSign   ? ({7'h00, signFlags} & metering_cfg_pkg::PHASE_SIGN_MASK) :
        16'h0000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_q <= 16'h0000;
        end else begin
            rdData_q <= rdMux;
        end
    end

    assign regRdData      = rdData_q;
    assign softResetPulse = softReset_q;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    wire       swapOn  = config_q[metering_cfg_pkg::CHANNEL_SWAP_BIT];
    wire       vGround = config_q[metering_cfg_pkg::VOLTAGE_ADC_GROUND_BIT];
    wire       iGround = config_q[metering_cfg_pkg::CURRENT_ADC_GROUND_BIT];
    wire [1:0] pickA = config_q[metering_cfg_pkg::PHASE_A_PICK_LSB +: 2];
    wire [1:0] pickB = config_q[metering_cfg_pkg::PHASE_B_PICK_LSB +: 2];
    wire [1:0] pickC = config_q[metering_cfg_pkg::PHASE_C_PICK_LSB +: 2];
    wire [1:0] perSrc = measMode_q[metering_cfg_pkg::PERIOD_SOURCE_LSB +: 2];
    wire [1:0] actMode = accumulation_mode_q[metering_cfg_pkg::ACTIVE_ACCUM_LSB +: 2];
    wire [1:0] reaMode = accumulation_mode_q[metering_cfg_pkg::REACTIVE_ACCUM_LSB +: 2];
    wire [1:0] connection_select  = accumulation_mode_q[metering_cfg_pkg::CONNECTION_LSB +: 2];

    assign integratorOn =
        config_q[metering_cfg_pkg::INTEGRATOR_ON_BIT]; // RULE1
    assign capturePortOn =
        config_q[metering_cfg_pkg::CAPTURE_PORT_ON_BIT];
    // Pin mux stays combinational so the capture clock keeps its edges
    assign sharedPin = capturePortOn ? captureClock : thirdPulse; // RULE5
    assign peakPhases = measMode_q[metering_cfg_pkg::PEAK_PICK_LSB +: 3];
    assign connectionSelect = connection_select; // RULE16

    // Reserved pick code resolves to the phase's own voltage
    wire [1:0] pickAEff = (pickA == metering_cfg_pkg::CODE_RESERVED)
                        ? 2'h0 : pickA; // RULE7
    wire [1:0] pickBEff = (pickB == metering_cfg_pkg::CODE_RESERVED)
                        ? 2'h0 : pickB; // RULE8
    wire [1:0] pickCEff = (pickC == metering_cfg_pkg::CODE_RESERVED)
                        ? 2'h0 : pickC; // RULE9
    wire [1:0] perEff = (perSrc == metering_cfg_pkg::CODE_RESERVED)
                      ? 2'h0 : perSrc; // RULE10

    // Absolute phase index for each current: offsets rotate A->B->C
    function automatic logic [1:0] rotate(input logic [1:0] base,
                                          input logic [1:0] ofs);
        logic [2:0] sum;
        sum = {1'b0, base} + {1'b0, ofs};
        rotate = (sum > 3'h2) ? 2'(sum - 3'h3) : sum[1:0];
    endfunction

    wire [1:0] srcA = rotate(2'h0, pickAEff);
    wire [1:0] srcB = rotate(2'h1, pickBEff);
    wire [1:0] srcC = rotate(2'h2, pickCEff);

    // ------------------------------------------------------------
    // Sample path: ground, then swap, then pairing
    // ------------------------------------------------------------
    logic [2:0][SW-1:0] vGnd;
    logic [2:0][SW-1:0] iGnd;
    logic [2:0][SW-1:0] vSel;
    logic [2:0][SW-1:0] iSel;
    logic [2:0][SW-1:0] voltChan_q;
    logic [2:0][SW-1:0] currChan_q;
    logic [2:0][SW-1:0] paired_q;

    assign vGnd = vGround ? '0 : voltAdc; // RULE3
    assign iGnd = iGround ? '0 : currAdc; // RULE4
    assign vSel = swapOn ? iGnd : vGnd;   // RULE2
    assign iSel = swapOn ? vGnd : iGnd;   // RULE2

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            voltChan_q <= '0;
            currChan_q <= '0;
            paired_q   <= '0;
        end else begin
            voltChan_q <= vSel;
            currChan_q <= iSel;
            paired_q[0] <= vSel[srcA]; // RULE7
            paired_q[1] <= vSel[srcB]; // RULE8
            paired_q[2] <= vSel[srcC]; // RULE9
        end
    end
    assign voltChan   = voltChan_q;
    assign currChan   = currChan_q;
    assign pairedVolt = paired_q;

    // ------------------------------------------------------------
    // Period source and peak window
    // ------------------------------------------------------------
    assign periodPhase = perEff;
    assign periodCross = zeroCross[perEff]; // RULE10

    // Each picked phase's crossing advances the same count
    wire [2:0] peakHits = zeroCross & peakPhases; // RULE11
    wire [1:0] hitCount = 2'(peakHits[0]) + 2'(peakHits[1]) + 2'(peakHits[2]);
    logic [8:0] peakCnt_q;
    logic       peakEnd_q;
    wire  [8:0] peakSum = peakCnt_q + {7'h00, hitCount};
    wire        peakDone = (peakCycles != 8'h00)
                        && (peakSum >= {1'b0, peakCycles});

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            peakCnt_q <= 9'h000;
            peakEnd_q <= 1'b0;
        end else begin
            peakEnd_q <= peakDone; // RULE12
            peakCnt_q <= peakDone ? 9'h000 : peakSum; // RULE12
        end
    end
    assign peakWindowEnd = peakEnd_q;

    // ------------------------------------------------------------
    // Energy accumulator inputs
    // ------------------------------------------------------------
    logic [2:0][PW-1:0] actNext;
    logic [2:0][PW-1:0] reaNext;
    logic [2:0][PW-1:0] appNext;
    logic [2:0][PW-1:0] act_q;
    logic [2:0][PW-1:0] rea_q;
    logic [2:0][PW-1:0] app_q;

    // Absolute mode wraps on the most negative value
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            actNext[p] = activePower[p];
            reaNext[p] = reactivePower[p];
            appNext[p] = apparentPower[p];
            if (actMode == metering_cfg_pkg::ACTIVE_ABSOLUTE
                && activePower[p][PW-1]) begin
                actNext[p] = -activePower[p]; // RULE13
            end
            if (reaMode == metering_cfg_pkg::REACTIVE_BY_ACTIVE
                && activePower[p][PW-1]) begin
                reaNext[p] = -reactivePower[p]; // RULE15
            end
        end
        if (connection_select == metering_cfg_pkg::CONN_THREE_WIRE) begin
            actNext[1] = '0; // RULE17
            reaNext[1] = '0;
            appNext[1] = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            act_q <= '0;
            rea_q <= '0;
            app_q <= '0;
        end else begin
            act_q <= actNext; // RULE13
            rea_q <= reaNext; // RULE14
            app_q <= appNext; // RULE16
        end
    end

    assign activeTerm   = act_q;
    assign reactiveTerm = rea_q;
    assign apparentTerm = app_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_soft_reset;
        @(posedge clk) disable iff (rst)
        resetReq |=> softResetPulse ##1
            (config_q == metering_cfg_pkg::DATAPATH_CONFIG_RST
             && measMode_q == metering_cfg_pkg::MEASUREMENT_MODE_RST);
    endproperty
    a_soft_reset: assert property (p_soft_reset) // RULE6
        else $error("soft reset did not restore defaults");

    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
        (config_q[15:14] == 2'h0) && (config_q[2:1] == 2'h0)
        && (measMode_q[7:5] == 3'h0) && (accumulation_mode_q[7:6] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // RULE18
        else $error("reserved bit became set");

    property p_swap;
        @(posedge clk) disable iff (rst)
        (swapOn && !vGround && !iGround) |=> voltChan == $past(currAdc);
    endproperty
    a_swap: assert property (p_swap) // RULE2
        else $error("swap did not route current to voltage channel");

    property p_vground;
        @(posedge clk) disable iff (rst)
        (vGround && !swapOn) |=> voltChan == '0;
    endproperty
    a_vground: assert property (p_vground) // RULE3
        else $error("grounded voltage channel not zero");

    property p_iground;
        @(posedge clk) disable iff (rst)
        (iGround && !swapOn) |=> currChan == '0;
    endproperty
    a_iground: assert property (p_iground) // RULE4
        else $error("grounded current channel not zero");

    property p_pin_mux;
        @(posedge clk) disable iff (rst)
        sharedPin == (capturePortOn ? captureClock : thirdPulse);
    endproperty
    a_pin_mux: assert property (p_pin_mux) // RULE5
        else $error("shared pin carries wrong function");

    property p_pick_a;
        @(posedge clk) disable iff (rst)
        (pickA == 2'h3 || pickA == 2'h0) |=> pairedVolt[0] == $past(vSel[0]);
    endproperty
    a_pick_a: assert property (p_pick_a) // RULE7
        else $error("phase A current paired with wrong voltage");

    property p_period;
        @(posedge clk) disable iff (rst)
        (perSrc == 2'h3) |-> periodPhase == 2'h0;
    endproperty
    a_period: assert property (p_period) // RULE10
        else $error("reserved period source not treated as phase A");

    property p_three_wire;
        @(posedge clk) disable iff (rst)
        (connection_select == metering_cfg_pkg::CONN_THREE_WIRE) |=>
            ({activeTerm[1], reactiveTerm[1], apparentTerm[1]} == '0);
    endproperty
    a_three_wire: assert property (p_three_wire) // RULE17
        else $error("phase B product not zero in three-wire mode");

    property p_signed_active;
        @(posedge clk) disable iff (rst)
        (actMode != 2'h3) |=> activeTerm[0] == $past(activePower[0]);
    endproperty
    a_signed_active: assert property (p_signed_active) // RULE13
        else $error("signed active accumulation altered value");

    property p_reactive_flip;
        @(posedge clk) disable iff (rst)
        (reaMode == 2'h2 && activePower[2][PW-1]) |=>
            reactiveTerm[2] == -$past(reactivePower[2]);
    endproperty
    a_reactive_flip: assert property (p_reactive_flip) // RULE15
        else $error("reactive sign not reversed on negative active");
endmodule

// File: tb/metering_datapath_config_tb.sv
`timescale 1ns/1ps
module metering_datapath_config_tb;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    localparam int SW = 8;
    localparam int PW = 16;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic [15:0] rdExp;
    } row_t;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic [15:0]        regAddr = 16'h0000;
    logic               regWrite = 1'b0;
    logic [15:0]        regWrData = 16'h0000;
    logic [15:0]        regRdData;
    logic [8:0]         signFlags = 9'h1a5;
    logic               integratorOn, softResetPulse, sharedPin;
    logic               capturePortOn, periodCross, peakWindowEnd;
    logic [2:0][SW-1:0] voltAdc = {8'h33, 8'h22, 8'h11};
    logic [2:0][SW-1:0] currAdc = {8'h66, 8'h55, 8'h44};
    logic [2:0][SW-1:0] voltChan, currChan, pairedVolt;
    logic               captureClock = 1'b1;
    logic               thirdPulse = 1'b0;
    logic [2:0]         zeroCross = 3'h0;
    logic [2:0]         peakPhases;
    logic [1:0]         periodPhase, connectionSelect;
    logic [7:0]         peakCycles = 8'h00;
    logic [2:0][PW-1:0] activePower = {16'hfd00, 16'h0200, 16'hff00};
    logic [2:0][PW-1:0] reactivePower = {16'h0030, 16'h0020, 16'h0010};
    logic [2:0][PW-1:0] apparentPower = {16'h3000, 16'h2000, 16'h1000};
    logic [2:0][PW-1:0] activeTerm, reactiveTerm, apparentTerm;
    logic [15:0]        cfg = 16'h0000;
    logic [7:0]         mm = 8'h1c;
    logic [7:0]         am = 8'h00;
    int                 n_fail = 0;
    int                 n_checks = 0;
    int                 cycles = 0;
    row_t               rows [$] = '{
        '{16'he618, 16'h0001, 16'h0001}, '{16'he618, 16'h0008, 16'h0008},
        '{16'he618, 16'h0010, 16'h0010}, '{16'he618, 16'h0020, 16'h0020},
        '{16'he618, 16'h0038, 16'h0038}, '{16'he618, 16'h0040, 16'h0040},
        '{16'he618, 16'h0100, 16'h0100}, '{16'he618, 16'h0200, 16'h0200},
        '{16'he618, 16'h0300, 16'h0300}, '{16'he618, 16'h0400, 16'h0400},
        '{16'he618, 16'h0800, 16'h0800}, '{16'he618, 16'h0c00, 16'h0c00},
        '{16'he618, 16'h1000, 16'h1000}, '{16'he618, 16'h2000, 16'h2000},
        '{16'he618, 16'h3000, 16'h3000}, '{16'he618, 16'hff7f, 16'h3f79},
        '{16'he618, 16'h0000, 16'h0000}, '{16'he700, 16'h0000, 16'h0000},
        '{16'he700, 16'h0001, 16'h0001}, '{16'he700, 16'h0002, 16'h0002},
        '{16'he700, 16'h0003, 16'h0003}, '{16'he700, 16'h00ff, 16'h001f},
        '{16'he700, 16'h001c, 16'h001c}, '{16'he701, 16'h0003, 16'h0003},
        '{16'he701, 16'h0001, 16'h0001}, '{16'he701, 16'h0002, 16'h0002},
        '{16'he701, 16'h0004, 16'h0004}, '{16'he701, 16'h0008, 16'h0008},
        '{16'he701, 16'h000c, 16'h000c}, '{16'he701, 16'h0010, 16'h0010},
        '{16'he701, 16'h0020, 16'h0020}, '{16'he701, 16'h0030, 16'h0030},
        '{16'he701, 16'h00ff, 16'h003f}, '{16'he701, 16'h00c0, 16'h0000},
        '{16'he617, 16'hffff, 16'h01a5}, '{16'he619, 16'hffff, 16'h0000}};

    always #10 clk = ~clk;

    metering_datapath_config #(.SW(SW), .PW(PW)) u_metering_datapath_config (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
        .regWrData(regWrData), .regRdData(regRdData), .signFlags(signFlags),
        .integratorOn(integratorOn), .softResetPulse(softResetPulse),
        .voltAdc(voltAdc), .currAdc(currAdc), .voltChan(voltChan),
        .currChan(currChan), .pairedVolt(pairedVolt),
        .captureClock(captureClock), .thirdPulse(thirdPulse),
        .sharedPin(sharedPin), .capturePortOn(capturePortOn),
        .zeroCross(zeroCross), .periodPhase(periodPhase),
        .periodCross(periodCross), .peakPhases(peakPhases),
        .peakCycles(peakCycles), .peakWindowEnd(peakWindowEnd),
        .activePower(activePower), .reactivePower(reactivePower),
        .apparentPower(apparentPower), .activeTerm(activeTerm),
        .reactiveTerm(reactiveTerm), .apparentTerm(apparentTerm),
        .connectionSelect(connectionSelect));

    // ------------------------------------------------------------
    // Bus cycles, compares and closing
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chkVal(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkVec(input string nm, input logic [47:0] e,
                          input logic [47:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrReg(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
    endtask

    task automatic rdReg(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        @(posedge clk);
        #1;
        d = regRdData;
    endtask

    // Expected outputs built from the bench's own copy of the registers
    task automatic checkOutputs();
        logic [2:0][SW-1:0] v, c, ev, ec, ep;
        logic [2:0][PW-1:0] ea, er, eq;
        logic [1:0]         code, per;
        v = cfg[4] ? '0 : voltAdc;
        c = cfg[5] ? '0 : currAdc;
        ev = cfg[3] ? c : v;
        ec = cfg[3] ? v : c;
        for (int i = 0; i < 3; i++) begin
            code = cfg[8 + 2 * i +: 2];
            if (code == 2'h3)
                code = 2'h0;
            ep[i] = voltAdc[(i + int'(code)) % 3];
            ea[i] = (am[1:0] == 2'h3 && activePower[i][PW-1]) ?
                    -activePower[i] : activePower[i];
            er[i] = (am[3:2] == 2'h2 && activePower[i][PW-1]) ?
                    -reactivePower[i] : reactivePower[i];
            eq[i] = apparentPower[i];
            if (am[5:4] == 2'h1 && i == 1) begin
                ea[i] = '0;
                er[i] = '0;
                eq[i] = '0;
            end
        end
        per = (mm[1:0] == 2'h3) ? 2'h0 : mm[1:0];
        @(posedge clk);
        #1;
        chkVal("integratorOn", 16'(cfg[0]), 16'(integratorOn));
        if (cfg[3]) begin
            chkVec("voltChan", 48'(ev), 48'(voltChan));
            chkVec("currChan", 48'(ec), 48'(currChan));
        end else begin
            chkVec("voltChan", 48'(ev), 48'(voltChan));
            chkVec("currChan", 48'(ec), 48'(currChan));
        end
        if (cfg[5:3] == 3'h0) begin
            chkVal("pairA", 16'(ep[0]), 16'(pairedVolt[0]));
            chkVal("pairB", 16'(ep[1]), 16'(pairedVolt[1]));
            chkVal("pairC", 16'(ep[2]), 16'(pairedVolt[2]));
        end
        chkVal("capturePortOn", 16'(cfg[6]), 16'(capturePortOn));
        chkVal("periodPhase", 16'(per), 16'(periodPhase));
        chkVal("peakPhases", 16'(mm[4:2]), 16'(peakPhases));
        chkVal("connection", 16'(am[5:4]), 16'(connectionSelect));
        chkVec("activeTerm", 48'(ea), 48'(activeTerm));
        chkVec("reactiveTerm", 48'(er), 48'(reactiveTerm));
        chkVec("apparentTerm", 48'(eq), 48'(apparentTerm));
        // Both pin sources are flipped so a stuck mux cannot pass
        for (int k = 0; k < 2; k++) begin
            chkVal("sharedPin", 16'(cfg[6] ? captureClock : thirdPulse),
                   16'(sharedPin));
            captureClock = ~captureClock;
            thirdPulse = ~thirdPulse;
            zeroCross = 3'h1 << per;
            @(posedge clk);
            #1;
        end
        chkVal("periodCross", 16'h0001, 16'(periodCross));
        zeroCross = 3'h0;
    endtask

    task automatic peakRun(input logic [2:0] zc, output int n);
        n = 0;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            #1;
            if (peakWindowEnd === 1'b1)
                n++;
            zeroCross = (k < 2) ? zc : 3'h0;
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] rd;
        int          n;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        foreach (rows[i]) begin
            wrReg(rows[i].addr, rows[i].data);
            rdReg(rows[i].addr, rd);
            chkVal("readback", rows[i].rdExp, rd);
            if (rows[i].addr == 16'he618)
                cfg = rows[i].rdExp;
            if (rows[i].addr == 16'he700)
                mm = rows[i].rdExp[7:0];
            if (rows[i].addr == 16'he701)
                am = rows[i].rdExp[7:0];
            checkOutputs();
        end
        wrReg(16'he618, 16'h0101);
        wrReg(16'he700, 16'h0000);
        wrReg(16'he618, 16'h0081);
        chkVal("softResetPulse", 16'h0001, 16'(softResetPulse));
        @(posedge clk);
        #1;
        chkVal("softResetPulse", 16'h0000, 16'(softResetPulse));
        rdReg(16'he618, rd);
        chkVal("configAfterSoft", 16'h0000, rd);
        rdReg(16'he700, rd);
        chkVal("modeAfterSoft", 16'h001c, rd);
        wrReg(16'he618, 16'h3f79);
        wrReg(16'he701, 16'h0033);
        // Mid-run reset also clears the peak window counter
        @(posedge clk);
        #1;
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        cfg = 16'h0000;
        mm = 8'h1c;
        am = 8'h00;
        rdReg(16'he618, rd);
        chkVal("configReset", 16'h0000, rd);
        rdReg(16'he700, rd);
        chkVal("modeReset", 16'h001c, rd);
        rdReg(16'he701, rd);
        chkVal("accumReset", 16'h0000, rd);
        checkOutputs();
        peakCycles = 8'h06;
        peakRun(3'h7, n);
        chkVal("peakPulsesAll", 16'h0001, 16'(n));
        wrReg(16'he700, 16'h0004);
        peakRun(3'h7, n);
        chkVal("peakPulsesOne", 16'h0000, 16'(n));
        test_done();
    end
endmodule
